// File: test_timer_mode_control_hlt.sv
// Self-checking bench for the timer mode control block.
// Assumes the checker and the trigger source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tmch_defines.svh"

module test_timer_mode_control_hlt;
	logic        clk_sys, arst_n, en, cyc, stb, we, ack, match, trig;
	logic [3:0]  sel, wsel;
	logic [7:0]  adr, cnt, v;
	logic [31:0] dat, rdat, q;
	int          fail_count, checks_done, mtally, m0;

	// Clock, design and trigger source; wsel sets the lanes of the next cycle
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	tmch_timer #(.WIDTH(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(en),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_reset_trigger(trig),
		.timer_count(cnt), .period_match(match));
	tmch_trig_src src (.clk_sys(clk_sys), .ext_reset_trigger(trig));
	// Tally of period match pulses
	always @(posedge clk_sys) begin
		if (match === 1'b1)
			mtally++;
	end

	// ------------------------
	// Shared tasks
	// ------------------------
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One classic cycle; read data lands in q at the ack edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= wsel;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			stop_test();
		end
	endtask
	function automatic logic [31:0] ctl(input logic [4:0] m, input logic dg, rn);
		return {19'h0, m, 6'h0, dg, rn};
	endfunction
	// Stop first so the count cannot run between the setup writes
	task automatic go(input logic [4:0] m, input logic dg, input logic [7:0] p);
		bus(1'b1, `TMCH_ADR_CTRL, ctl(m, dg, 1'b0));
		bus(1'b1, `TMCH_ADR_PERIOD, {24'h0, p});
		bus(1'b1, `TMCH_ADR_COUNT, 32'h0);
		bus(1'b1, `TMCH_ADR_CTRL, ctl(m, dg, 1'b1));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// ------------------------
	// Scenarios
	// ------------------------
	task automatic t_reset;
		bus(1'b0, `TMCH_ADR_PERIOD, 32'h0);
		chk("period reset", q, 32'hff);
		bus(1'b0, `TMCH_ADR_COUNT, 32'h0);
		chk("count reset", q, 32'h0);
		bus(1'b0, 8'h10, 32'h0);
		chk("unmapped", q, 32'h0);
	endtask
	task automatic t_free;
		int mx;
		go(5'h00, 1'b0, 8'h05);
		mx = 0;
		repeat (20) begin
			@(negedge clk_sys);
			if (cnt > mx)
				mx = cnt;
		end
		chk("wrap top", 32'(mx), 32'h5);
		bus(1'b1, `TMCH_ADR_CTRL, ctl(5'h00, 1'b0, 1'b0));
		tick(1);
		v = cnt;
		src.put(1'b1);
		chk("halt", cnt, v);
	endtask
	task automatic t_gate;
		for (int i = 1; i < 3; i++) begin
			src.put(i == 2);
			go(5'(i), 1'b0, 8'hff);
			tick(8);
			chk("gate shut", cnt, 32'h0);
			go(5'(i), 1'b1, 8'hff);
			tick(8);
			chk("debug open", cnt != 0, 32'h1);
			go(5'(i), 1'b0, 8'hff);
			src.put(i == 1);
			chk("gate open", cnt != 0, 32'h1);
		end
	endtask
	task automatic t_edge;
		for (int i = 3; i < 6; i++) begin
			src.put(1'b0);
			go(5'(i), 1'b0, 8'hff);
			tick(20);
			src.put(1'b1);
			chk("rise reset", cnt < 12, i != 5);
			tick(20);
			src.put(1'b0);
			chk("fall reset", cnt < 12, i != 4);
		end
		for (int i = 6; i < 8; i++) begin
			src.put(i == 7);
			go(5'(i), 1'b0, 8'hff);
			tick(8);
			chk("level hold", cnt, 32'h0);
			src.put(i != 7);
			chk("level free", cnt != 0, 32'h1);
		end
	endtask
	task automatic t_oneshot;
		m0 = mtally;
		go(5'h08, 1'b0, 8'h04);
		tick(14);
		chk("shot stop", cnt, 32'h0);
		chk("shot once", mtally - m0, 32'h1);
		bus(1'b0, `TMCH_ADR_CTRL, 32'h0);
		chk("shot run off", q[0], 32'h0);
		for (int i = 1; i < 4; i++) begin
			src.put(i == 2);
			go(5'h08 + 5'(i), 1'b0, 8'hff);
			tick(8);
			chk("shot wait", cnt, 32'h0);
			src.put(i != 2);
			chk("shot fire", cnt != 0, 32'h1);
		end
		bus(1'b1, `TMCH_ADR_CTRL, ctl(5'h09, 1'b0, 1'b0));
		bus(1'b1, `TMCH_ADR_CTRL, ctl(5'h09, 1'b0, 1'b1));
		tick(1);
		v = cnt;
		tick(8);
		chk("no fresh edge", cnt, v);
		src.put(1'b0);
		chk("wrong edge", cnt, v);
		src.put(1'b1);
		chk("fresh edge", cnt != v, 32'h1);
	endtask
	task automatic t_mono;
		src.put(1'b0);
		m0 = mtally;
		go(5'h11, 1'b0, 8'h03);
		src.put(1'b1);
		tick(8);
		chk("mono stop", cnt, 32'h0);
		chk("mono once", mtally - m0, 32'h1);
		bus(1'b0, `TMCH_ADR_CTRL, 32'h0);
		chk("mono run kept", q[0], 32'h1);
		go(5'h18, 1'b0, 8'hff);
		bus(1'b1, `TMCH_ADR_COUNT, 32'h07);
		tick(10);
		chk("reserved hold", cnt, 32'h07);
	endtask
	// Debug edges, one-shot resets, level monostable, status, byte lanes,
	// clock enable and a reset in mid-run
	task automatic t_hw;
		src.put(1'b0);
		go(5'h04, 1'b1, 8'hff);
		tick(20);
		src.put(1'b1);
		chk("debug edge", cnt > 12, 32'h1);
		src.put(1'b0);
		go(5'h0c, 1'b0, 8'hff);
		tick(4);
		chk("rise wait", cnt, 32'h0);
		src.put(1'b1);
		chk("rise start", cnt != 0, 32'h1);
		tick(20);
		src.put(1'b0);
		src.put(1'b1);
		chk("rise reset again", cnt < 12, 32'h1);
		go(5'h0e, 1'b0, 8'hff);
		src.put(1'b0);
		chk("level wait", cnt, 32'h0);
		src.put(1'b1);
		chk("edge start", cnt != 0, 32'h1);
		tick(10);
		src.put(1'b0);
		chk("low reset", cnt, 32'h0);
		go(5'h16, 1'b0, 8'hff);
		tick(4);
		chk("mono held", cnt, 32'h0);
		src.put(1'b1);
		chk("mono level start", cnt != 0, 32'h1);
		bus(1'b0, `TMCH_ADR_STATUS, 32'h0);
		chk("status", q, 32'h6);
		src.put(1'b0);
		chk("mono low reset", cnt, 32'h0);
		bus(1'b1, `TMCH_ADR_CTRL, ctl(5'h00, 1'b0, 1'b0));
		bus(1'b1, `TMCH_ADR_COUNT, 32'h21);
		wsel = 4'he;
		bus(1'b1, `TMCH_ADR_COUNT, 32'h55);
		wsel = 4'hf;
		bus(1'b0, `TMCH_ADR_COUNT, 32'h0);
		chk("lane gate", q, 32'h21);
		bus(1'b1, `TMCH_ADR_CTRL, ctl(5'h00, 1'b0, 1'b1));
		@(posedge clk_sys);
		en <= 1'b0;
		@(negedge clk_sys);
		v = cnt;
		tick(10);
		chk("enable freeze", cnt, v);
		@(posedge clk_sys);
		en <= 1'b1;
		tick(2);
		chk("enable thaw", cnt != v, 32'h1);
		bus(1'b1, `TMCH_ADR_PERIOD, 32'h40);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		bus(1'b0, `TMCH_ADR_PERIOD, 32'h0);
		chk("reset period", q, 32'hff);
		bus(1'b0, `TMCH_ADR_CTRL, 32'h0);
		chk("reset control", q, 32'h0);
		chk("reset count", cnt, 32'h0);
	endtask

	// Reset, then every scenario in turn
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		en = 1'b1;
		sel = 4'hf;
		wsel = 4'hf;
		arst_n = 1'b0;
		fail_count = 0;
		checks_done = 0;
		mtally = 0;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_free();
		t_gate();
		t_edge();
		t_oneshot();
		t_mono();
		t_hw();
		stop_test();
	end
endmodule
`default_nettype wire

// File: tmch_defines.svh
// Constants for the timer mode control block: register offsets, field
// positions, reset values and mode codes.
// Assumes inclusion by bare name from files in the same folder.
`ifndef TMCH_DEFINES_SVH
`define TMCH_DEFINES_SVH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define TMCH_ADR_CTRL    8'h00
`define TMCH_ADR_PERIOD  8'h04
`define TMCH_ADR_COUNT   8'h08
`define TMCH_ADR_STATUS  8'h0c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TMCH_CTRL_RUN    0
`define TMCH_CTRL_DBG    1
`define TMCH_CTRL_MODE_LO 8
`define TMCH_CTRL_MODE_HI 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMCH_PERIOD_RST  8'hff
`define TMCH_COUNT_RST   8'h00
`define TMCH_MODE_RST    5'h00

// ----------------------------------------
// Mode group codes (upper two bits)
// ----------------------------------------
`define TMCH_GRP_FREE    2'h0
`define TMCH_GRP_ONESHOT 2'h1
`define TMCH_GRP_MONO    2'h2

// Lower three bits
`define TMCH_LO_0 3'h0
`define TMCH_LO_1 3'h1
`define TMCH_LO_2 3'h2
`define TMCH_LO_3 3'h3
`define TMCH_LO_4 3'h4
`define TMCH_LO_5 3'h5
`define TMCH_LO_6 3'h6
`define TMCH_LO_7 3'h7

`endif

// File: tmch_pkg.sv
// Types shared by the timer mode control block.
// Assumes the defines header is compiled alongside.
package tmch_pkg;

	// Counter run state
	typedef enum logic [1:0] {
		TMCH_IDLE,
		TMCH_ARMED,
		TMCH_RUN
	} tmch_state_t;

	// Decoded control settings travel together
	typedef struct packed {
		logic [4:0] mode;
		logic       run;
		logic       dbg;
	} tmch_ctrl_t;

	// Edge and level view of the synchronised trigger
	typedef struct packed {
		logic lvl;
		logic rise;
		logic fall;
	} tmch_trig_t;

endpackage

// File: tmch_regs.sv
// Small register store for the period word with a registered
// read port. Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "tmch_defines.svh"

module tmch_regs #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [1:0]       wr_sel,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic [1:0]       rd_sel,
	output logic      [WIDTH-1:0] rd_data,
	// Period always visible to the counter
	output logic      [WIDTH-1:0] period_value
);

	logic [WIDTH-1:0] rd_data_ff;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Period register initialises to all ones
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			period_value <= `TMCH_PERIOD_RST;
		end else if (clk_en && wr_en && wr_sel == 2'h1) begin
			period_value <= wr_data;
		end
	end

	// Registered read keeps bus timing regular
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_ff <= `TMCH_PERIOD_RST; // Matches the period store at once
		end else if (clk_en) begin
			rd_data_ff <= (rd_sel == 2'h1) ? period_value : '0;
		end
	end

	assign rd_data = rd_data_ff;

endmodule
`default_nettype wire

// File: tmch_timer.sv
// Mode control for an 8-bit period timer with hardware limit, reached
// over classic Wishbone. Assumes clk_sys is the prescaled timer clock
// and the trigger pin arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "tmch_defines.svh"

module tmch_timer #(
	parameter int WIDTH = 8
) (
	// Clock, reset and enable
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// External reset or trigger pin
	input  wire logic             ext_reset_trigger,
	// Timer outputs
	output logic      [WIDTH-1:0] timer_count,
	output logic                  period_match
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	tmch_pkg::tmch_ctrl_t  ctrl_ff;
	tmch_pkg::tmch_trig_t  trig;
	tmch_pkg::tmch_state_t state_ff;
	tmch_pkg::tmch_state_t nxt_state;
	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	logic [WIDTH-1:0] period_limit;
	logic [WIDTH-1:0] mem_rd;
	logic [31:0]      dat_ff;
	logic             ack_ff;
	logic             match_ff;
	logic             sync1_ff;
	logic             sync2_ff;
	logic             prev_ff;
	logic             clear_run;
	logic             bus_req;
	logic             bus_wr;
	logic             wr_ctrl;
	logic             wr_count;
	logic [1:0]       grp;
	logic [2:0]       lo;
	logic             is_match;
	logic             start_ev;
	logic             reset_ev;
	logic             gate_ok;

	assign grp      = ctrl_ff.mode[4:3];
	assign lo       = ctrl_ff.mode[2:0];
	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
	assign wr_ctrl  = bus_wr && wb_adr_i == `TMCH_ADR_CTRL;
	assign wr_count = bus_wr && wb_adr_i == `TMCH_ADR_COUNT;
	assign is_match = count_ff == period_limit;

	// ----------------------------------------
	// Trigger synchroniser and edge view
	// ----------------------------------------
	// Two flops before use; prev_ff follows the second for edges
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end else if (clk_en) begin
			sync1_ff <= ext_reset_trigger;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// Debug blanks the trigger edges only; the level view passes through unmasked
	always_comb begin
		trig.lvl  = sync2_ff;
		trig.rise = sync2_ff && !prev_ff && !ctrl_ff.dbg;
		trig.fall = !sync2_ff && prev_ff && !ctrl_ff.dbg;
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Start, reset and gate terms per mode; source timing of the
	// trigger is trusted so no glitch filter here.
	always_comb begin
		start_ev     = 1'b0;
		reset_ev     = 1'b0;
		gate_ok      = 1'b1;
		case (grp)
			`TMCH_GRP_FREE: begin
				case (lo)
					`TMCH_LO_1: gate_ok = ctrl_ff.dbg || trig.lvl;
					`TMCH_LO_2: gate_ok = ctrl_ff.dbg || !trig.lvl;
					`TMCH_LO_3: reset_ev = trig.rise || trig.fall;
					`TMCH_LO_4: reset_ev = trig.rise;
					`TMCH_LO_5: reset_ev = trig.fall;
					`TMCH_LO_6: reset_ev = !ctrl_ff.dbg && !trig.lvl;
					`TMCH_LO_7: reset_ev = !ctrl_ff.dbg && trig.lvl;
					default: gate_ok = 1'b1;
				endcase
			end
			// One-shot: the period match clears run
			`TMCH_GRP_ONESHOT: begin
				case (lo)
					`TMCH_LO_0: start_ev = 1'b1;
					`TMCH_LO_1: start_ev = trig.rise;
					`TMCH_LO_2: start_ev = trig.fall;
					`TMCH_LO_3: start_ev = trig.rise || trig.fall;
					`TMCH_LO_4: begin
						start_ev = trig.rise;
						reset_ev = trig.rise;
					end
					`TMCH_LO_5: begin
						start_ev = trig.fall;
						reset_ev = trig.fall;
					end
					`TMCH_LO_6: begin
						start_ev = trig.rise;
						reset_ev = !ctrl_ff.dbg && !trig.lvl;
					end
					default: begin
						start_ev = trig.fall;
						reset_ev = !ctrl_ff.dbg && trig.lvl;
					end
				endcase
			end
			// Monostable edge modes keep run at the match
			`TMCH_GRP_MONO: begin
				case (lo)
					`TMCH_LO_1: start_ev = trig.rise;
					`TMCH_LO_2: start_ev = trig.fall;
					`TMCH_LO_3: start_ev = trig.rise || trig.fall;
					`TMCH_LO_6: begin
						start_ev = !ctrl_ff.dbg && trig.lvl;
						reset_ev = !ctrl_ff.dbg && !trig.lvl;
					end
					`TMCH_LO_7: begin
						start_ev = !ctrl_ff.dbg && !trig.lvl;
						reset_ev = !ctrl_ff.dbg && trig.lvl;
					end
					default: gate_ok = 1'b0;
				endcase
			end
			default: gate_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Run state and counter next values
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		clear_run = 1'b0;
		if (!ctrl_ff.run) begin
			// Edge modes drop back to waiting so a fresh edge is needed
			nxt_state = tmch_pkg::TMCH_IDLE;
		end else if (grp == `TMCH_GRP_FREE) begin
			nxt_state = tmch_pkg::TMCH_RUN;
			if (reset_ev) begin
				nxt_count = `TMCH_COUNT_RST;
			end else if (gate_ok) begin
				nxt_count = is_match ? `TMCH_COUNT_RST : count_ff + 1'b1;
			end
		end else if (!gate_ok) begin
			nxt_state = tmch_pkg::TMCH_IDLE;
		end else begin
			case (state_ff)
				tmch_pkg::TMCH_IDLE: begin
					if (start_ev) begin
						nxt_state = tmch_pkg::TMCH_RUN;
					end
				end
				tmch_pkg::TMCH_RUN: begin
					if (reset_ev) begin
						nxt_count = `TMCH_COUNT_RST;
					end else if (is_match) begin
						nxt_count = `TMCH_COUNT_RST;
						nxt_state = tmch_pkg::TMCH_IDLE;
						clear_run = grp == `TMCH_GRP_ONESHOT
							|| lo[2:1] == 2'h3;
					end else begin
						nxt_count = count_ff + 1'b1;
					end
				end
				default: nxt_state = tmch_pkg::TMCH_IDLE;
			endcase
			// Monostable level modes clear the count and idle while held, restarting on the level alone
			if (grp == `TMCH_GRP_MONO && lo[2:1] == 2'h3 && reset_ev) begin
				nxt_state = tmch_pkg::TMCH_IDLE;
				nxt_count = `TMCH_COUNT_RST;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= tmch_pkg::TMCH_IDLE;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	// Counter; a bus write wins over the count update
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= `TMCH_COUNT_RST;
		end else if (clk_en) begin
			if (wr_count) begin
				count_ff <= wb_dat_i[WIDTH-1:0];
			end else begin
				count_ff <= nxt_count;
			end
		end
	end

	// Match pulse marks each period event
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			match_ff <= 1'b0;
		end else if (clk_en) begin
			match_ff <= ctrl_ff.run && is_match && nxt_count == `TMCH_COUNT_RST
				&& !reset_ev;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Hardware clear of run loses to a software write in the same cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff.mode <= `TMCH_MODE_RST;
			ctrl_ff.run  <= 1'b0;
			ctrl_ff.dbg  <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_ff.mode <= wb_dat_i[`TMCH_CTRL_MODE_HI:`TMCH_CTRL_MODE_LO];
				ctrl_ff.run  <= wb_dat_i[`TMCH_CTRL_RUN];
				ctrl_ff.dbg  <= wb_dat_i[`TMCH_CTRL_DBG];
			end else if (clear_run) begin
				ctrl_ff.run <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	tmch_regs #(
		.WIDTH(WIDTH)
	) u_regs (
		.clk_sys      (clk_sys),
		.arst_n       (arst_n),
		.clk_en       (clk_en),
		.wr_en        (bus_wr && wb_adr_i == `TMCH_ADR_PERIOD),
		.wr_sel       (2'h1),
		.wr_data      (wb_dat_i[WIDTH-1:0]),
		.rd_sel       (2'h1),
		.rd_data      (mem_rd),
		.period_value (period_limit)
	);

	// One-cycle ack, dropped the cycle after; unmapped reads give zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				if (wb_adr_i == `TMCH_ADR_CTRL) begin
					dat_ff <= {19'h0, ctrl_ff.mode, 6'h00, ctrl_ff.dbg, ctrl_ff.run};
				end else if (wb_adr_i == `TMCH_ADR_PERIOD) begin
					// Registered store port; the ack cycle after a period write
					// blocks any read, so the port already holds the new value
					dat_ff <= {{(32-WIDTH){1'b0}}, mem_rd};
				end else if (wb_adr_i == `TMCH_ADR_COUNT) begin
					dat_ff <= {{(32-WIDTH){1'b0}}, count_ff};
				end else if (wb_adr_i == `TMCH_ADR_STATUS) begin
					dat_ff <= {29'h0, sync2_ff, state_ff};
				end else begin
					dat_ff <= 32'h0000_0000;
				end
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o     = ack_ff;
	assign wb_dat_o     = dat_ff;
	assign timer_count  = count_ff;
	assign period_match = match_ff;

endmodule
`default_nettype wire

// File: tmch_timer_checker.sv
// Port checker for tmch_timer, bound in at the foot of this file.
// Assumes one clock domain; clk_en is high whenever timing is judged.
`timescale 1ns/1ps
`default_nettype none
`include "tmch_defines.svh"

module tmch_timer_checker #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic             clk_sys,
	input wire logic             arst_n,
	input wire logic             clk_en,
	// Bus
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [7:0]       wb_adr_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	// Trigger and timer
	input wire logic             ext_reset_trigger,
	input wire logic [WIDTH-1:0] timer_count,
	input wire logic             period_match
);
	// ------------------------
	// Sequences and helpers
	// ------------------------
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
	endsequence
	sequence s_cnt_wr;
		s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `TMCH_ADR_COUNT);
	endsequence
	// A taken count write may move the count anywhere, so it excuses a jump
	logic cnt_wr_ff;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			cnt_wr_ff <= 1'b0;
		else
			cnt_wr_ff <= wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en && wb_we_i
				&& wb_sel_i[0] && wb_adr_i == `TMCH_ADR_COUNT;
	end

	// ------------------------
	// Assertions
	// ------------------------
	ack_in_one_a: assert property (s_take |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	unmapped_zero_a: assert property (s_take ##0 (!wb_we_i && wb_adr_i > `TMCH_ADR_STATUS)
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	count_write_a: assert property (s_cnt_wr |=> timer_count == $past(wb_dat_i[WIDTH-1:0]))
		else $error("count write lost");
	count_read_a: assert property (s_take ##0 (!wb_we_i && wb_adr_i == `TMCH_ADR_COUNT)
		|=> wb_dat_o[WIDTH-1:0] == $past(timer_count)) else $error("count read wrong");
	count_step_a: assert property (!cnt_wr_ff && timer_count != $past(timer_count)
		&& timer_count != '0 |-> timer_count == $past(timer_count) + 1'b1)
		else $error("count moved by other than one");
	match_zero_a: assert property (period_match |-> timer_count == '0)
		else $error("count not zero after period match");
endmodule

bind tmch_timer tmch_timer_checker #(.WIDTH(WIDTH)) u_tmch_chk (
	.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ext_reset_trigger(ext_reset_trigger), .timer_count(timer_count),
	.period_match(period_match)
);
`default_nettype wire

// File: tmch_trig_src.sv
// Model of the external reset or trigger source.
// Assumes the bench calls put and waits for it to return.
`timescale 1ns/1ps
`default_nettype none

module tmch_trig_src (
	// Clock
	input wire logic clk_sys,
	// Trigger pin
	output logic     ext_reset_trigger
);
	// Pin is always driven, so it starts low
	initial ext_reset_trigger = 1'b0;
	// Every level is held at least seven clocks, which spaces edges and stretches levels
	task automatic put(input logic v);
		@(posedge clk_sys);
		ext_reset_trigger <= v;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
endmodule
`default_nettype wire
